// >>> design/eeprom_slave_pkg.sv
// Constants, timing figures and state codes of the two-wire memory slave
package eeprom_slave_pkg;

  // ==========================================================
  // Clock and timing figures
  localparam int CLK_MHZ = 40;
  localparam int FILTER_NS = 250;
  localparam int FILTER_CYC = (FILTER_NS * CLK_MHZ + 999) / 1000;
  localparam int PROG_MIN_MS = 20;
  localparam int PROG_MAX_MS = 100;
  localparam int PROG_MIN_CYC = PROG_MIN_MS * CLK_MHZ * 1000;
  localparam int PROG_MAX_CYC = PROG_MAX_MS * CLK_MHZ * 1000;

  // ==========================================================
  // Array, byte and transfer layout
  localparam int MEM_WORDS = 256;
  localparam int ADDR_W = 8;
  localparam int BYTE_W = 8;
  localparam logic [3:0] LAST_BIT = 4'h8;
  localparam logic [1:0] MAX_WRITE_BYTES = 2'h2;
  localparam logic [ADDR_W-1:0] PTR_RST = 8'h00;
  localparam logic [3:0] DEV_TYPE_DEFAULT = 4'hA;
  localparam int BUF_DEPTH_DEFAULT = 2;

  // Bus receive and transmit states
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_DEV  = 7'h02,
    ST_WORD = 7'h04,
    ST_WDAT = 7'h08,
    ST_ACK  = 7'h10,
    ST_RDAT = 7'h20,
    ST_MACK = 7'h40
  } bus_state_type;

endpackage

// >>> design/eeprom_slave.sv
// Two-wire serial slave of a 256 x 8 electrically erasable memory
`timescale 1ns/1ps

module eeprom_slave import eeprom_slave_pkg::*; #(
  parameter int PROG_MIN_CYCLES = PROG_MIN_CYC,
  parameter int PROG_MAX_CYCLES = PROG_MAX_CYC,
  parameter logic [3:0] DEV_TYPE = DEV_TYPE_DEFAULT,
  parameter int BUF_DEPTH = BUF_DEPTH_DEFAULT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Two-wire bus, data line open drain
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Strapped chip address
  input wire logic chip_addr_bit0_pin,
  input wire logic chip_addr_bit1_pin,
  input wire logic chip_addr_bit2_pin,
  // Programming time from the external network, high when elapsed
  input wire logic program_timing_network_input,
  // Status
  output logic program_busy
);

  localparam int TW = $clog2(PROG_MAX_CYCLES + 1);
  localparam int FW = $clog2(FILTER_CYC + 1);
  localparam int BW = ADDR_W + BYTE_W;
  localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam logic [TW-1:0] MIN_LAST = TW'(PROG_MIN_CYCLES - 1);
  localparam logic [TW-1:0] MAX_LAST = TW'(PROG_MAX_CYCLES - 1);
  localparam logic [FW-1:0] FILT_LAST = FW'(FILTER_CYC - 1);

  // Refuse settings the timer or buffer cannot serve
  if (PROG_MIN_CYCLES < 1 || PROG_MAX_CYCLES < PROG_MIN_CYCLES ||
      BUF_DEPTH < 2) begin : g_bad_param
    $error("eeprom_slave: bad timing or buffer parameter");
  end

  // Slave address match: type prefix and chip bits
  function automatic logic dev_match(input logic [7:0] b, input logic [2:0] chip);
    dev_match = (b[7:4] == DEV_TYPE) && (b[3:1] == chip);
  endfunction

  // ==========================================================
  // Input synchronisers and glitch filter
  logic [1:0] sync1_r;
  logic [1:0] sync2_r;
  logic [1:0] filt_r;
  logic [1:0] filt_prev_r;
  logic [FW-1:0] filt_cnt_r [2];
  logic [2:0] strap1_r;
  logic [2:0] strap2_r;
  logic rc1_r;
  logic rc2_r;

  // Two flops before any logic sees a pin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_r <= 2'h3;
      sync2_r <= 2'h3;
      strap1_r <= 3'h0;
      strap2_r <= 3'h0;
      rc1_r <= 1'b0;
      rc2_r <= 1'b0;
    end else begin
      sync1_r <= {sda_in, scl_in};
      sync2_r <= sync1_r;
      strap1_r <= {chip_addr_bit2_pin, chip_addr_bit1_pin, chip_addr_bit0_pin};
      strap2_r <= strap1_r;
      rc1_r <= program_timing_network_input;
      rc2_r <= rc1_r;
    end
  end

  // A new level is taken only after it held for the filter time
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      filt_r <= 2'h3;
      filt_prev_r <= 2'h3;
      filt_cnt_r[0] <= '0;
      filt_cnt_r[1] <= '0;
    end else begin
      filt_prev_r <= filt_r;
      for (int i = 0; i < 2; i++) begin
        if (sync2_r[i] == filt_r[i]) begin
          filt_cnt_r[i] <= '0;
        end else if (filt_cnt_r[i] == FILT_LAST) begin
          filt_r[i] <= sync2_r[i];
          filt_cnt_r[i] <= '0;
        end else begin
          filt_cnt_r[i] <= filt_cnt_r[i] + 1'b1;
        end
      end
    end
  end

  // Bus events from the filtered lines
  logic scl_f;
  logic sda_f;
  logic scl_rise;
  logic scl_fall;
  logic start_evt;
  logic stop_evt;
  assign scl_f = filt_r[0];
  assign sda_f = filt_r[1];
  assign scl_rise = scl_f & ~filt_prev_r[0];
  assign scl_fall = ~scl_f & filt_prev_r[0];
  // Data edge under a held high clock is never data
  assign start_evt = scl_f & filt_prev_r[0] & filt_prev_r[1] & ~sda_f;
  assign stop_evt = scl_f & filt_prev_r[0] & ~filt_prev_r[1] & sda_f;

  // ==========================================================
  // Bus state machine
  bus_state_type state_r;
  bus_state_type after_r;
  bus_state_type after_nxt;
  logic [3:0] bitcnt_r;
  logic [7:0] shift_r;
  logic [ADDR_W-1:0] ptr_r;
  logic [1:0] wbytes_r;
  logic sda_oe_r;
  logic sda_out_r;
  logic commit_r;
  logic byte_end;
  logic push;
  logic rx_ack;
  logic in_ready;
  logic [BYTE_W-1:0] mem [MEM_WORDS];
  logic [BYTE_W-1:0] cur_byte;

  assign cur_byte = mem[ptr_r];
  assign byte_end = scl_fall && (bitcnt_r == LAST_BIT);
  // Third write byte or a full buffer is not acknowledged
  assign push = (state_r == ST_WDAT) && byte_end && in_ready &&
                (wbytes_r < MAX_WRITE_BYTES);

  // Acknowledge decision at the end of a received byte
  always_comb begin
    rx_ack = 1'b0;
    after_nxt = ST_IDLE;
    unique case (state_r)
      ST_DEV: begin
        rx_ack = dev_match(shift_r, strap2_r) && !commit_r;
        after_nxt = shift_r[0] ? ST_RDAT : ST_WORD;
      end
      ST_WORD: begin
        rx_ack = 1'b1;
        after_nxt = ST_WDAT;
      end
      ST_WDAT: begin
        rx_ack = push;
        after_nxt = ST_WDAT;
      end
      ST_IDLE, ST_ACK, ST_RDAT, ST_MACK: begin
        rx_ack = 1'b0;
        after_nxt = ST_IDLE;
      end
    endcase
  end

  // Transfer sequencing; start and stop override any bit in flight
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      after_r <= ST_IDLE;
      bitcnt_r <= 4'h0;
      shift_r <= 8'h00;
      ptr_r <= PTR_RST;
      wbytes_r <= 2'h0;
      sda_oe_r <= 1'b0;
    end else if (start_evt) begin
      state_r <= ST_DEV;
      bitcnt_r <= 4'h0;
      wbytes_r <= 2'h0;
      sda_oe_r <= 1'b0;
    end else if (stop_evt) begin
      state_r <= ST_IDLE;
      sda_oe_r <= 1'b0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          sda_oe_r <= 1'b0;
        end
        ST_DEV, ST_WORD, ST_WDAT: begin
          if (scl_rise) begin
            shift_r <= {shift_r[6:0], sda_f};
            bitcnt_r <= bitcnt_r + 4'h1;
          end else if (byte_end) begin
            bitcnt_r <= 4'h0;
            after_r <= after_nxt;
            sda_oe_r <= rx_ack;
            state_r <= rx_ack ? ST_ACK : ST_IDLE;
            if (state_r == ST_WORD) begin
              ptr_r <= shift_r;
            end
            if (push) begin
              ptr_r <= ptr_r + 1'b1;
              wbytes_r <= wbytes_r + 2'h1;
            end
          end
        end
        ST_ACK: begin
          // Low held until the clock falls again
          if (scl_fall) begin
            state_r <= after_r;
            shift_r <= cur_byte;
            sda_oe_r <= (after_r == ST_RDAT) && !cur_byte[7];
          end
        end
        ST_RDAT: begin
          if (scl_rise) begin
            bitcnt_r <= bitcnt_r + 4'h1;
          end else if (byte_end) begin
            bitcnt_r <= 4'h0;
            sda_oe_r <= 1'b0;
            state_r <= ST_MACK;
          end else if (scl_fall) begin
            shift_r <= {shift_r[6:0], 1'b0};
            sda_oe_r <= !shift_r[6];
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            if (!sda_f) begin
              ptr_r <= ptr_r + 1'b1;
            end else begin
              state_r <= ST_IDLE;
            end
          end else if (scl_fall) begin
            shift_r <= cur_byte;
            sda_oe_r <= !cur_byte[7];
            state_r <= ST_RDAT;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Write buffer between the bus and the programming timer
  logic [BW-1:0] buf_mem [BUF_DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [PW:0] count_r;
  logic out_valid;
  logic pop;
  assign in_ready = count_r < (PW+1)'(BUF_DEPTH);
  assign out_valid = count_r != '0;

  // Full buffer holds back the bus by refusing the acknowledge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == PW'(BUF_DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == PW'(BUF_DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r <= count_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // Entries hold address and data
  always_ff @(posedge clk) begin
    if (push) begin
      buf_mem[wr_ptr_r] <= {ptr_r, shift_r};
    end
  end

  // ==========================================================
  // Self-timed programming, one timed cycle per word
  logic [TW-1:0] tmr_r;
  logic program_busy_r;
  logic [BW-1:0] head;
  assign head = buf_mem[rd_ptr_r];
  // Ends when the network reports, bounded by the least and longest times
  assign pop = commit_r && out_valid &&
               ((tmr_r >= MIN_LAST && rc2_r) || tmr_r >= MAX_LAST);

  // Stop releases queued words to the timer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      commit_r <= 1'b0;
      tmr_r <= '0;
      program_busy_r <= 1'b0;
    end else begin
      if (stop_evt && out_valid) begin
        commit_r <= 1'b1;
      end else if (!out_valid) begin
        commit_r <= 1'b0;
      end
      if (commit_r && out_valid && !pop) begin
        tmr_r <= tmr_r + 1'b1;
      end else begin
        tmr_r <= '0;
      end
      program_busy_r <= commit_r;
    end
  end

  // Array update at the end of each word's cycle
  always_ff @(posedge clk) begin
    if (pop) begin
      mem[head[BW-1:BYTE_W]] <= head[BYTE_W-1:0];
    end
  end

  // Open drain: only ever pulls low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sda_out_r <= 1'b0;
    end else begin
      sda_out_r <= 1'b0;
    end
  end

  assign sda_out = sda_out_r;
  assign sda_oe = sda_oe_r;
  assign program_busy = program_busy_r;

  // ==========================================================
  // Checks
  chk_ptr_on_ack: assert property (@(posedge clk) disable iff (rst)
    (state_r == ST_MACK && scl_rise && !sda_f && !start_evt && !stop_evt)
    |=> ptr_r == $past(ptr_r) + 1'b1)
    else $error("pointer did not advance on acknowledge");

  chk_ptr_hold_nack: assert property (@(posedge clk) disable iff (rst)
    (state_r == ST_MACK && scl_rise && sda_f) |=> $stable(ptr_r))
    else $error("pointer moved without acknowledge");

  chk_release_nack: assert property (@(posedge clk) disable iff (rst)
    (state_r == ST_MACK && scl_rise && sda_f) |=> (!sda_oe_r && state_r == ST_IDLE)[*2])
    else $error("data line not released after no acknowledge");

  chk_addr_ack_sel: assert property (@(posedge clk) disable iff (rst)
    (state_r == ST_DEV && byte_end && !start_evt && !stop_evt &&
     shift_r[3:1] != strap2_r) |=> !sda_oe_r && state_r == ST_IDLE)
    else $error("acknowledged a foreign chip address");

  chk_prefix_ignore: assert property (@(posedge clk) disable iff (rst)
    (state_r == ST_DEV && byte_end && shift_r[7:4] != DEV_TYPE) |=> !sda_oe_r)
    else $error("acknowledged a foreign device type");

  chk_busy_nack: assert property (@(posedge clk) disable iff (rst)
    (state_r == ST_DEV && byte_end && commit_r) |=> !sda_oe_r)
    else $error("acknowledged while programming");

  chk_word_ack: assert property (@(posedge clk) disable iff (rst)
    (state_r == ST_WORD && byte_end && !start_evt && !stop_evt)
    |=> sda_oe_r && state_r == ST_ACK)
    else $error("word address not acknowledged");

  chk_two_bytes: assert property (@(posedge clk) disable iff (rst)
    push |-> wbytes_r < MAX_WRITE_BYTES)
    else $error("more than two write bytes taken");

  chk_prog_time: assert property (@(posedge clk) disable iff (rst)
    pop |-> (tmr_r >= MIN_LAST && tmr_r <= MAX_LAST))
    else $error("word programming time out of range");

  chk_prog_after_stop: assert property (@(posedge clk) disable iff (rst)
    (tmr_r != '0) |-> commit_r && $past(commit_r))
    else $error("programming ran before stop");

  chk_filter_hold: assert property (@(posedge clk) disable iff (rst)
    (filt_r[0] != filt_prev_r[0]) |-> $past(filt_cnt_r[0]) == FILT_LAST)
    else $error("clock level taken before filter time");

endmodule

// >>> test/bus_master_model.sv
// Behavioural two-wire bus master that drives clock and data
`timescale 1ns/1ps

module bus_master_model (
  // Clock
  input wire logic clk,
  // Bus lines
  input wire logic sda_line,
  output logic scl,
  output logic sda_oe,
  // One result per byte or acknowledge
  output logic [7:0] res_byte,
  output logic res_tgl,
  output logic ack_line
);
  // ==========================================================
  // Bus timing in 25 ns cycles
  localparam int T_LOW = 188; // 4.7 us low phase
  localparam int T_HIGH = 160; // 4.0 us high phase
  localparam int T_SET = 20; // Hold after the clock falls

  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
    res_byte = 8'h00;
    res_tgl = 1'b0;
    ack_line = 1'b1;
  end

  // Falling edges only, so no change races the sampling edge
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Data changes only while the clock is low
  task automatic put_bit(input logic b);
    wait_cyc(T_SET);
    sda_oe = !b;
    wait_cyc(T_LOW - T_SET);
    scl = 1'b1;
    wait_cyc(T_HIGH);
    ack_line = sda_line;
    scl = 1'b0;
  endtask

  // Sampled twice; a low that does not hold reads as high
  task automatic get_bit(output logic b);
    logic s0;
    wait_cyc(T_SET);
    sda_oe = 1'b0;
    wait_cyc(T_LOW - T_SET);
    scl = 1'b1;
    wait_cyc(10);
    s0 = sda_line;
    wait_cyc(T_HIGH - 20);
    b = s0 | sda_line;
    wait_cyc(10);
    scl = 1'b0;
  endtask

  task automatic post(input logic [7:0] v);
    res_byte = v;
    res_tgl = !res_tgl;
  endtask

  // Start from idle or clock low: data falls while clock high
  task automatic bus_start();
    wait_cyc(T_SET);
    sda_oe = 1'b0;
    if (!scl) begin
      wait_cyc(T_LOW - T_SET);
      scl = 1'b1;
    end
    wait_cyc(T_LOW);
    sda_oe = 1'b1;
    wait_cyc(T_HIGH);
    scl = 1'b0;
  endtask

  // Stop: data rises while clock high, then bus free time
  task automatic bus_stop();
    wait_cyc(T_SET);
    sda_oe = 1'b1;
    wait_cyc(T_LOW - T_SET);
    scl = 1'b1;
    wait_cyc(T_LOW);
    sda_oe = 1'b0;
    wait_cyc(T_LOW);
  endtask

  // Eight bits MSB first, ninth pulse reads the acknowledge
  task automatic send_byte(input logic [7:0] b);
    logic a;
    for (int i = 7; i >= 0; i--) put_bit(b[i]);
    get_bit(a);
    post({7'h00, a});
  endtask

  // Acknowledge every byte but the last wanted
  task automatic recv_byte(input logic ack_it);
    logic [7:0] d;
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(!ack_it);
    post(d);
  endtask
endmodule

// >>> test/tb.sv
// Self-checking bench of the two-wire memory slave
`timescale 1ns/1ps

module tb;
  // ==========================================================
  // Short programming bounds keep the run brief
  localparam int P_MIN = 2000;
  localparam int P_MAX = 4000;
  localparam logic [3:0] TYPE = 4'ha; // Arbitrary prefix value

  logic clk;
  logic rst;
  logic scl;
  logic m_oe;
  logic sda_out;
  logic sda_oe;
  logic sda_line;
  logic [2:0] strap;
  logic net_in;
  logic program_busy;
  logic [7:0] res_byte;
  logic res_tgl;
  logic ack_line;
  logic [7:0] exp_q[$];
  logic [7:0] d0;
  logic [7:0] d1;
  int errors;
  int total_checks;
  int busy_cyc;

  // Open-drain data wire with a pull-up
  assign sda_line = !((sda_oe && !sda_out) || m_oe);

  eeprom_slave #(
    .PROG_MIN_CYCLES(P_MIN), .PROG_MAX_CYCLES(P_MAX), .DEV_TYPE(TYPE), .BUF_DEPTH(2)
  ) dut (
    .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .chip_addr_bit0_pin(strap[0]), .chip_addr_bit1_pin(strap[1]),
    .chip_addr_bit2_pin(strap[2]), .program_timing_network_input(net_in),
    .program_busy(program_busy)
  );

  bus_master_model master (
    .clk(clk), .sda_line(sda_line), .scl(scl), .sda_oe(m_oe),
    .res_byte(res_byte), .res_tgl(res_tgl), .ack_line(ack_line)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Busy length, zeroed by the driver before the stop that ends each write
  always @(posedge clk) begin
    if (program_busy === 1'b1) busy_cyc <= busy_cyc + 1;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Monitor: each result from the master takes the oldest note
  // Armed only after reset, so the model's time-zero setup is not a result
  initial begin
    wait (rst === 1'b0);
    forever begin
      @(res_tgl);
      if (exp_q.size() == 0) begin
        errors++;
        $display("mismatch at %0t: unexpected result", $time);
      end else begin
        chk(res_byte, exp_q.pop_front());
      end
    end
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    finish_test();
  end

  // ==========================================================
  // Driver helpers: note the expectation, then run the byte
  task automatic wr(input logic [7:0] b, input logic ack);
    exp_q.push_back({7'h00, !ack});
    master.send_byte(b);
  endtask

  task automatic rd(input logic [7:0] e, input logic ack);
    exp_q.push_back(e);
    master.recv_byte(ack);
  endtask

  function automatic logic [7:0] dev(input logic [2:0] chip, input logic rw);
    return {TYPE, chip, rw};
  endfunction

  // Bounded wait for programming to end, then its length
  task automatic wait_prog(input int lo, input int hi);
    int n;
    n = 0;
    while (program_busy !== 1'b0 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    chk({7'h00, busy_cyc >= lo && busy_cyc <= hi}, 8'h01);
  endtask

  initial begin
    rst = 1'b1;
    net_in = 1'b1;
    errors = 0;
    total_checks = 0;
    busy_cyc = 0;
    void'($urandom(32'he3a9_a20e));
    strap = 3'($urandom);
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    chk({6'h00, sda_oe, program_busy}, 8'h00);
    // Two-byte write across the top of the array
    master.bus_start();
    wr(dev(strap, 1'b0), 1'b1);
    wr(8'hff, 1'b1);
    wr(d0, 1'b1);
    wr(d1, 1'b1);
    chk({7'h00, program_busy}, 8'h00);
    busy_cyc = 0;
    master.bus_stop();
    // Poll during programming is refused
    master.bus_start();
    wr(dev(strap, 1'b0), 1'b0);
    master.bus_stop();
    wait_prog(2 * P_MIN - 10, 2 * P_MIN + 30);
    // Random read over the wrap, acknowledged then not
    master.bus_start();
    wr(dev(strap, 1'b0), 1'b1);
    wr(8'hff, 1'b1);
    master.bus_start();
    wr(dev(strap, 1'b1), 1'b1);
    rd(d0, 1'b1);
    rd(d1, 1'b0);
    chk({7'h00, ack_line}, 8'h01);
    master.bus_stop();
    // Pointer held at the byte that was not acknowledged
    master.bus_start();
    wr(dev(strap, 1'b1), 1'b1);
    rd(d1, 1'b0);
    master.bus_stop();
    // Wrong chip bits, then wrong prefix
    master.bus_start();
    wr(dev(strap ^ 3'(1 + $urandom_range(6)), 1'b1), 1'b0);
    master.bus_stop();
    master.bus_start();
    wr({~TYPE, strap, 1'b0}, 1'b0);
    master.bus_stop();
    // Third data byte refused; slow network holds each word to the ceiling
    net_in = 1'b0;
    master.bus_start();
    wr(dev(strap, 1'b0), 1'b1);
    wr(8'h10, 1'b1);
    wr(d0, 1'b1);
    wr(d1, 1'b1);
    wr(d0 ^ d1, 1'b0);
    busy_cyc = 0;
    master.bus_stop();
    wait_prog(2 * P_MAX - 10, 2 * P_MAX + 30);
    chk(8'(exp_q.size()), 8'h00);
    finish_test();
  end
endmodule
